/* File: rtl/dssm_top.sv */
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "dssm_defines.svh"
module dssm_top #(
  parameter int SEC_CYC = `DSSM_SEC_CYC,
  parameter int MS_CYC  = `DSSM_MS_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        stage_select_input_1,
  input  wire logic        stage_select_input_2,
  input  wire logic        stage_select_input_3,
  input  wire logic        stage_select_input_4,
  input  wire logic        term_run,
  input  wire logic [15:0] motor_freq,
  input  wire logic [15:0] power_w,
  input  wire logic        power_down,
  output logic      [15:0] freq_cmd,
  output logic             running,
  output logic             mesh_conn,
  output logic             yd_term,
  output logic      [2:0]  active_motor,
  output logic             energy_save
);
  logic             req;
  logic             wr;
  logic [5:0]       idx;
  logic [15:0]      wd;
  logic [31:0]      rd_d;
  logic [1:0]       src_q;
  logic             yd_en_q;
  logic             vf_q;
  logic             key_run_q;
  logic             comm_run_q;
  logic [15:0]      primary_q;
  logic [15:0]      yd_freq_q;
  logic [15:0]      yd_delay_q;
  logic [15:0]      poles_q;
  logic [15:0]      rpm_q;
  logic [15:0]      stage_q [1:15];
  logic [15:0]      plc_q [0:19];
  logic [3:0]       code;
  logic [15:0]      sel_freq;
  logic             run_d;
  logic [25:0]      sec_cnt_q;
  logic             sec_tick;
  logic             clr_energy;
  logic [21:0]      res_q;
  logic [22:0]      res_sum;
  logic             kwh_inc;
  logic [15:0]      esec_hi;
  logic [15:0]      esec_lo;
  logic [15:0]      ekwh_hi;
  logic [15:0]      ekwh_lo;
  logic [10:0]      ot_min;
  logic [15:0]      ot_day;
  logic             want_d;
  logic [15:0]      ms_pre_q;
  logic [15:0]      dly_q;
  dssm_pkg::dssm_yd_t st_q;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Registers are 16 bits wide, so both low lanes must be enabled to write
  assign wr  = req && wb_we_i && wb_sel_i[0] && wb_sel_i[1];
  assign idx = wb_adr_i[7:2];
  assign wd  = wb_dat_i[15:0];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd_d;
    end
  end

  always_comb begin
    rd_d = 32'h0;
    case (idx)
      `DSSM_A_CTRL:    rd_d[6:0] = {active_motor - 3'h1, vf_q, yd_en_q, src_q};
      `DSSM_A_RUNCMD:  rd_d[1:0] = {comm_run_q, key_run_q};
      `DSSM_A_YDFREQ:  rd_d[15:0] = yd_freq_q;
      `DSSM_A_YDDLY:   rd_d[15:0] = yd_delay_q;
      `DSSM_A_POLES:   rd_d[15:0] = poles_q;
      `DSSM_A_RPM:     rd_d[15:0] = rpm_q;
      `DSSM_A_STATUS:  rd_d[7:0] = {code, yd_term, mesh_conn, energy_save, running};
      `DSSM_A_FREQCMD: rd_d[15:0] = freq_cmd;
      `DSSM_A_ESEC_LO: rd_d[15:0] = esec_lo;
      `DSSM_A_ESEC_HI: rd_d[15:0] = esec_hi;
      `DSSM_A_EKWH_LO: rd_d[15:0] = ekwh_lo;
      `DSSM_A_EKWH_HI: rd_d[15:0] = ekwh_hi;
      `DSSM_A_OT_MIN:  rd_d[10:0] = ot_min;
      `DSSM_A_OT_DAY:  rd_d[15:0] = ot_day;
      `DSSM_A_PRIMARY: rd_d[15:0] = primary_q;
      default: begin
        if (idx >= `DSSM_A_STAGE1 && idx <= `DSSM_A_STAGE15) begin
          rd_d[15:0] = stage_q[idx[3:0] + 4'h1];
        end else if (idx >= `DSSM_A_PLC0 && idx <= `DSSM_A_PLC19) begin
          rd_d[15:0] = plc_q[5'(idx - `DSSM_A_PLC0)];
        end
      end
    endcase
  end

  // Control and motor configuration
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      src_q        <= dssm_pkg::SRC_TERM;
      yd_en_q      <= 1'b0;
      vf_q         <= 1'b1;
      active_motor <= 3'h1;
      key_run_q    <= 1'b0;
      comm_run_q   <= 1'b0;
      primary_q    <= 16'h0;
      yd_freq_q    <= `DSSM_YDFREQ_RST;
      yd_delay_q   <= `DSSM_YDDLY_RST;
      poles_q      <= `DSSM_POLES_RST;
      rpm_q        <= `DSSM_RPM_RST;
    end else begin
      if (!vf_q) begin
        active_motor <= 3'h1;
      end
      if (wr) begin
        case (idx)
          `DSSM_A_CTRL: begin
            src_q   <= wd[`DSSM_F_SRC_HI:`DSSM_F_SRC_LO];
            yd_en_q <= wd[`DSSM_F_YDEN];
            vf_q    <= wd[`DSSM_F_VF];
            // Other motors only under V/F; otherwise motor 1 is kept
            if (wd[`DSSM_F_VF] && wd[`DSSM_F_MOT_HI] == 1'b0) begin
              active_motor <= {1'b0, wd[5:4]} + 3'h1;
            end else begin
              active_motor <= 3'h1;
            end
          end
          `DSSM_A_RUNCMD: begin
            key_run_q  <= wd[0];
            comm_run_q <= wd[1];
          end
          `DSSM_A_PRIMARY: primary_q <= wd;
          `DSSM_A_YDFREQ: begin
            if (wd <= `DSSM_FREQ_MAX) yd_freq_q <= wd;
          end
          `DSSM_A_YDDLY: begin
            if (wd <= `DSSM_YDDLY_MAX) yd_delay_q <= wd;
          end
          `DSSM_A_POLES: begin
            if (!wd[0] && wd >= `DSSM_POLES_MIN && wd <= `DSSM_POLES_MAX) begin
              poles_q <= wd;
            end
          end
          `DSSM_A_RPM: rpm_q <= wd;
          default: begin
          end
        endcase
      end
    end
  end

  // Stage table stays writable while the motor runs
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 1; i <= 15; i++) stage_q[i] <= 16'h0;
    end else if (wr && idx >= `DSSM_A_STAGE1 && idx <= `DSSM_A_STAGE15 &&
                 wd <= `DSSM_FREQ_MAX) begin
      stage_q[idx[3:0] + 4'h1] <= wd;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 20; i++) plc_q[i] <= 16'h0;
    end else if (wr && idx >= `DSSM_A_PLC0 && idx <= `DSSM_A_PLC19) begin
      plc_q[5'(idx - `DSSM_A_PLC0)] <= wd;
    end
  end

  assign code = {stage_select_input_4, stage_select_input_3,
                 stage_select_input_2, stage_select_input_1};
  assign sel_freq = (code == 4'h0) ? primary_q : stage_q[code];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      freq_cmd <= 16'h0;
    end else begin
      freq_cmd <= sel_freq;
    end
  end

  always_comb begin
    case (src_q)
      dssm_pkg::SRC_TERM: run_d = term_run;
      dssm_pkg::SRC_KEY:  run_d = key_run_q;
      dssm_pkg::SRC_COMM: run_d = comm_run_q;
      default:            run_d = 1'b0;
    endcase
    if (power_down) run_d = 1'b0;
  end

  // Save strobe marks stop or power loss; totals simply hold afterwards
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      running     <= 1'b0;
      energy_save <= 1'b0;
    end else begin
      running     <= run_d;
      energy_save <= running && !run_d;
    end
  end

  assign sec_tick = running && (sec_cnt_q == 26'(SEC_CYC - 1));
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !running) begin
      sec_cnt_q <= 26'h0;
    end else begin
      sec_cnt_q <= sec_tick ? 26'h0 : sec_cnt_q + 26'h1;
    end
  end

  assign clr_energy = wr && idx == `DSSM_A_PRESET && wd == `DSSM_CLR_CODE;
  assign res_sum    = {1'b0, res_q} + {7'h0, power_w};
  assign kwh_inc    = sec_tick && res_sum >= {1'b0, `DSSM_WS_PER_KWH};

  always_ff @(posedge ref_clk) begin
    if (!rst_n || clr_energy) begin
      res_q <= 22'h0;
    end else if (sec_tick) begin
      res_q <= kwh_inc ? 22'(res_sum - {1'b0, `DSSM_WS_PER_KWH}) : res_sum[21:0];
    end
  end

  dssm_acc u_wsec (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clr     (clr_energy),
    .add_en  (sec_tick),
    .add_val ({16'h0, power_w}),
    .hi_word (esec_hi),
    .lo_word (esec_lo)
  );

  dssm_acc u_kwh (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clr     (clr_energy),
    .add_en  (kwh_inc),
    .add_val (32'h1),
    .hi_word (ekwh_hi),
    .lo_word (ekwh_lo)
  );

  dssm_optime u_optime (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .run      (running),
    .sec_tick (sec_tick),
    .clr_min  (wr && idx == `DSSM_A_OT_MIN && wd == 16'h0),
    .clr_day  (wr && idx == `DSSM_A_OT_DAY && wd == 16'h0),
    .min_q    (ot_min),
    .day_q    (ot_day)
  );

  assign want_d = yd_en_q && (motor_freq >= yd_freq_q);

  // Connection and parameter set move first; the terminal follows the delay
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q      <= dssm_pkg::YD_Y;
      mesh_conn <= 1'b0;
      yd_term   <= 1'b0;
      ms_pre_q  <= 16'h0;
      dly_q     <= 16'h0;
    end else begin
      ms_pre_q <= (ms_pre_q == 16'(MS_CYC - 1)) ? 16'h0 : ms_pre_q + 16'h1;
      if (ms_pre_q == 16'(MS_CYC - 1) && dly_q != 16'hffff) dly_q <= dly_q + 16'h1;
      case (st_q)
        dssm_pkg::YD_Y: begin
          if (want_d) begin
            st_q      <= dssm_pkg::YD_TO_D;
            mesh_conn <= 1'b1;
            ms_pre_q  <= 16'h0;
            dly_q     <= 16'h0;
          end
        end
        dssm_pkg::YD_TO_D: begin
          if (!want_d) begin
            st_q      <= dssm_pkg::YD_Y;
            mesh_conn <= 1'b0;
          end else if (dly_q >= yd_delay_q) begin
            st_q    <= dssm_pkg::YD_D;
            yd_term <= 1'b1;
          end
        end
        dssm_pkg::YD_D: begin
          if (!want_d) begin
            st_q      <= dssm_pkg::YD_TO_Y;
            mesh_conn <= 1'b0;
            ms_pre_q  <= 16'h0;
            dly_q     <= 16'h0;
          end
        end
        dssm_pkg::YD_TO_Y: begin
          if (want_d) begin
            st_q      <= dssm_pkg::YD_D;
            mesh_conn <= 1'b1;
          end else if (dly_q >= yd_delay_q) begin
            st_q    <= dssm_pkg::YD_Y;
            yd_term <= 1'b0;
          end
        end
        default: begin
          st_q      <= dssm_pkg::YD_Y;
          mesh_conn <= 1'b0;
          yd_term   <= 1'b0;
        end
      endcase
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  stage_pick_a: assert property (code != 4'h0 |=> freq_cmd == $past(stage_q[code]))
    else $error("stage frequency not selected");
  primary_pick_a: assert property (code == 4'h0 |=> freq_cmd == $past(primary_q))
    else $error("primary frequency not kept");
  yd_off_a: assert property (!yd_en_q && st_q == dssm_pkg::YD_Y |=> !mesh_conn)
    else $error("switch active while disabled");
  yd_freq_a: assert property (wr && idx == `DSSM_A_YDFREQ && wd > `DSSM_FREQ_MAX
    |=> $stable(yd_freq_q))
    else $error("threshold out of range taken");
  swap_sync_a: assert property ($changed(mesh_conn) |-> mesh_conn == $past(want_d))
    else $error("parameter swap out of step");
  yd_delay_a: assert property ($rose(yd_term) |-> $past(dly_q) >= $past(yd_delay_q))
    else $error("changeover output too early");
  motor_vf_a: assert property (!vf_q |-> active_motor == 3'h1)
    else $error("motor selection outside V/F");
  pole_even_a: assert property (!poles_q[0] && poles_q >= `DSSM_POLES_MIN
    && poles_q <= `DSSM_POLES_MAX)
    else $error("pole count illegal");
  save_run_a: assert property ($fell(running) |-> energy_save)
    else $error("energy not saved on stop");
endmodule : dssm_top

/* File: rtl/dssm_defines.svh */
`ifndef DSSM_DEFINES_SVH
`define DSSM_DEFINES_SVH
`define DSSM_CLK_PERIOD_NS 25
`define DSSM_MS_NS         1000000
`define DSSM_SEC_NS        1000000000
`define DSSM_MS_CYC        (`DSSM_MS_NS / `DSSM_CLK_PERIOD_NS)
`define DSSM_SEC_CYC       (`DSSM_SEC_NS / `DSSM_CLK_PERIOD_NS)
`define DSSM_A_CTRL        6'h00
`define DSSM_A_RUNCMD      6'h01
`define DSSM_A_PRESET      6'h02
`define DSSM_A_YDFREQ      6'h03
`define DSSM_A_YDDLY       6'h04
`define DSSM_A_POLES       6'h05
`define DSSM_A_RPM         6'h06
`define DSSM_A_STATUS      6'h07
`define DSSM_A_FREQCMD     6'h08
`define DSSM_A_ESEC_LO     6'h09
`define DSSM_A_ESEC_HI     6'h0a
`define DSSM_A_EKWH_LO     6'h0b
`define DSSM_A_EKWH_HI     6'h0c
`define DSSM_A_OT_MIN      6'h0d
`define DSSM_A_OT_DAY      6'h0e
`define DSSM_A_PRIMARY     6'h0f
`define DSSM_A_STAGE1      6'h10
`define DSSM_A_STAGE15     6'h1e
`define DSSM_A_PLC0        6'h20
`define DSSM_A_PLC19       6'h33
`define DSSM_F_SRC_LO      0
`define DSSM_F_SRC_HI      1
`define DSSM_F_YDEN        2
`define DSSM_F_VF          3
`define DSSM_F_MOT_LO      4
`define DSSM_F_MOT_HI      6
`define DSSM_FREQ_MAX      16'h3a98
`define DSSM_YDFREQ_RST    16'h1770
`define DSSM_YDDLY_MAX     16'hea60
`define DSSM_YDDLY_RST     16'h00c8
`define DSSM_POLES_MIN     16'h0002
`define DSSM_POLES_MAX     16'h0014
`define DSSM_POLES_RST     16'h0004
`define DSSM_RPM_RST       16'h06ae
`define DSSM_CLR_CODE      16'h0005
`define DSSM_MIN_MAX       11'h59f
`define DSSM_SEC_PER_MIN   6'h3b
`define DSSM_WS_PER_KWH    22'h36ee80
`endif

/* File: rtl/dssm_pkg.sv */
package dssm_pkg;
  typedef enum logic [3:0] {
    YD_Y    = 4'b0001,
    YD_TO_D = 4'b0010,
    YD_D    = 4'b0100,
    YD_TO_Y = 4'b1000
  } dssm_yd_t;
  typedef enum logic [1:0] {
    SRC_TERM = 2'h0,
    SRC_KEY  = 2'h1,
    SRC_COMM = 2'h2
  } dssm_src_t;
endpackage : dssm_pkg

/* File: rtl/dssm_acc.sv */
`timescale 1ns/10ps
`include "dssm_defines.svh"
module dssm_acc (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  input  wire logic        add_en,
  input  wire logic [31:0] add_val,
  output logic      [15:0] hi_word,
  output logic      [15:0] lo_word
);
  logic [31:0] acc_q;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || clr) begin
      acc_q <= 32'h0;
    end else if (add_en) begin
      acc_q <= acc_q + add_val;
    end
  end
  // Word split keeps full value = hi * 65536 + lo
  assign hi_word = acc_q[31:16];
  assign lo_word = acc_q[15:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  acc_clear_a: assert property (clr |=> acc_q == 32'h0)
    else $error("accumulator not cleared");
  acc_hold_a: assert property (!add_en && !clr |=> $stable(acc_q))
    else $error("accumulator moved while idle");
  acc_add_a: assert property (add_en && !clr |=>
    {hi_word, lo_word} == $past(acc_q) + $past(add_val))
    else $error("accumulator sum wrong");
endmodule : dssm_acc

/* File: rtl/dssm_optime.sv */
`timescale 1ns/10ps
`include "dssm_defines.svh"
module dssm_optime (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic        sec_tick,
  input  wire logic        clr_min,
  input  wire logic        clr_day,
  output logic      [10:0] min_q,
  output logic      [15:0] day_q
);
  logic [5:0] sec_q;
  logic       min_tick;
  assign min_tick = run && sec_tick && (sec_q == `DSSM_SEC_PER_MIN);
  // A stop discards the partial minute
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !run || clr_min) begin
      sec_q <= 6'h0;
    end else if (sec_tick) begin
      sec_q <= min_tick ? 6'h0 : sec_q + 6'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || clr_min) begin
      min_q <= 11'h0;
    end else if (min_tick) begin
      min_q <= (min_q == `DSSM_MIN_MAX) ? 11'h0 : min_q + 11'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n || clr_day) begin
      day_q <= 16'h0;
    end else if (min_tick && min_q == `DSSM_MIN_MAX) begin
      day_q <= day_q + 16'h1;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  min_wrap_a: assert property (min_tick && min_q == `DSSM_MIN_MAX && !clr_min && !clr_day
    |=> min_q == 11'h0 && day_q == $past(day_q) + 16'h1)
    else $error("minute wrap wrong");
  min_range_a: assert property (min_q <= `DSSM_MIN_MAX)
    else $error("minute count out of range");
  short_run_a: assert property (!run |=> sec_q == 6'h0 ##1 (!run || sec_q <= 6'h1))
    else $error("partial minute kept after stop");
  clr_time_a: assert property (clr_min || clr_day
    |=> (!$past(clr_min) || min_q == 11'h0) && (!$past(clr_day) || day_q == 16'h0))
    else $error("operation time not cleared");
endmodule : dssm_optime

/* File: tb/dssm_term_model.sv */
`timescale 1ns/10ps
module dssm_term_model (
  input  wire logic        ref_clk,
  input  wire logic [3:0]  code,
  input  wire logic [15:0] freq_set,
  output logic             stage_select_input_1,
  output logic             stage_select_input_2,
  output logic             stage_select_input_3,
  output logic             stage_select_input_4,
  output logic      [15:0] motor_freq
);
  // Contacts settle one edge after a change, like a debounced terminal
  always_ff @(posedge ref_clk) begin
    stage_select_input_1 <= code[0];
    stage_select_input_2 <= code[1];
    stage_select_input_3 <= code[2];
    stage_select_input_4 <= code[3];
    motor_freq           <= freq_set;
  end
endmodule : dssm_term_model

/* File: tb/tb_drive_speed_select_and_metering.sv */
`timescale 1ns/10ps
`include "dssm_defines.svh"
module tb_drive_speed_select_and_metering;
  logic        ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, code;
  logic [31:0] wb_dat_i, wb_dat_o, lo, hi, tot, tot2;
  logic        wb_ack_o, term_run, power_down, running, mesh_conn, yd_term, energy_save;
  logic        stage_select_input_1, stage_select_input_2;
  logic        stage_select_input_3, stage_select_input_4;
  logic [15:0] motor_freq, power_w, freq_cmd, freq_set;
  logic [2:0]  active_motor;
  int          failures, cmp_count, saves, s0, i;

  dssm_top #(.SEC_CYC(8), .MS_CYC(4)) dut (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .stage_select_input_1, .stage_select_input_2, .stage_select_input_3,
    .stage_select_input_4, .term_run, .motor_freq, .power_w, .power_down,
    .freq_cmd, .running, .mesh_conn, .yd_term, .active_motor, .energy_save);

  dssm_term_model term (.ref_clk, .code, .freq_set, .stage_select_input_1,
    .stage_select_input_2, .stage_select_input_3, .stage_select_input_4, .motor_freq);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // The save strobe lasts one cycle, so it is counted rather than polled
  always @(posedge ref_clk) begin
    if (energy_save === 1'b1) saves++;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] ba(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction : ba

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : tick

  // Entered just after an edge; request held until ack is seen at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     output logic [31:0] q);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) begin
      $display("[FAIL] %0t bus answer timeout", $time);
      failures++;
      conclude();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, ba(idx), d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 16'h0000, q);
    chk(q, exp);
  endtask : rdc

  task automatic energy(output logic [31:0] t);
    bus(1'b0, ba(`DSSM_A_ESEC_LO), 16'h0000, lo);
    bus(1'b0, ba(`DSSM_A_ESEC_HI), 16'h0000, hi);
    t = {hi[15:0], lo[15:0]};
  endtask : energy

  task automatic wait_yd(input logic v);
    int n;
    for (n = 0; n < 60 && yd_term !== v; n++) @(posedge ref_clk);
    if (n == 60) begin
      $display("[FAIL] %0t changeover output timeout", $time);
      failures++;
      conclude();
    end
  endtask : wait_yd

  initial begin
    #2500000;
    $display("[FAIL] %0t run timeout", $time);
    failures++;
    conclude();
  end

  initial begin
    rst_n = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, term_run, power_down} = 5'h00;
    {wb_adr_i, wb_dat_i, code, freq_set, power_w} = '0;
    wb_sel_i = 4'hf;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(ba(`DSSM_A_YDFREQ), 32'h1770);
    rdc(ba(`DSSM_A_YDDLY), 32'hc8);
    rdc(ba(`DSSM_A_POLES), 32'h4);
    rdc(ba(`DSSM_A_RPM), 32'h6ae);
    rdc(ba(`DSSM_A_CTRL), 32'h8);
    rdc(ba(`DSSM_A_STAGE15), 32'h0);
    rdc(ba(`DSSM_A_PLC19), 32'h0);
    chk(active_motor, 32'h1);
    $display("test reset done");
    for (i = 1; i < 16; i++) wr(`DSSM_A_STAGE1 + 6'(i - 1), 16'(i * 1000));
    wr(`DSSM_A_PRIMARY, 16'h0123);
    wr(`DSSM_A_STAGE1, 16'h3a99);
    rdc(ba(`DSSM_A_STAGE1), 32'h3e8);
    for (i = 0; i < 16; i++) begin
      code <= 4'(i);
      tick(3);
      chk(freq_cmd, (i == 0) ? 32'h123 : 32'(i * 1000));
    end
    code <= 4'h0;
    wr(`DSSM_A_PLC19, 16'hffff);
    rdc(ba(`DSSM_A_PLC19), 32'hffff);
    wb_sel_i <= 4'h1;
    wr(`DSSM_A_PLC0, 16'h0055);
    wb_sel_i <= 4'hf;
    rdc(ba(`DSSM_A_PLC0), 32'h0);
    rdc(8'hfc, 32'h0);
    $display("test stages done");
    term_run <= 1'b1;
    tick(3);
    chk(running, 32'h1);
    term_run <= 1'b0;
    wr(`DSSM_A_CTRL, 16'h9);
    wr(`DSSM_A_RUNCMD, 16'h1);
    chk(running, 32'h1);
    wr(`DSSM_A_RUNCMD, 16'h2);
    chk(running, 32'h0);
    wr(`DSSM_A_CTRL, 16'ha);
    chk(running, 32'h1);
    wr(`DSSM_A_CTRL, 16'hb);
    chk(running, 32'h0);
    wr(`DSSM_A_RUNCMD, 16'h0);
    wr(`DSSM_A_CTRL, 16'h28);
    chk(active_motor, 32'h3);
    wr(`DSSM_A_CTRL, 16'h20);
    chk(active_motor, 32'h1);
    wr(`DSSM_A_CTRL, 16'h68);
    chk(active_motor, 32'h1);
    wr(`DSSM_A_POLES, 16'h5);
    wr(`DSSM_A_POLES, 16'h16);
    rdc(ba(`DSSM_A_POLES), 32'h4);
    wr(`DSSM_A_POLES, 16'h14);
    rdc(ba(`DSSM_A_POLES), 32'h14);
    $display("test config done");
    wr(`DSSM_A_CTRL, 16'h8);
    freq_set <= 16'h1770;
    tick(4);
    chk(mesh_conn, 32'h0);
    wr(`DSSM_A_YDDLY, 16'h5);
    wr(`DSSM_A_CTRL, 16'hc);
    chk(mesh_conn, 32'h1);
    tick(10);
    chk(yd_term, 32'h0);
    wait_yd(1'b1);
    rdc(ba(`DSSM_A_STATUS), 32'hc);
    freq_set <= 16'h176f;
    tick(3);
    chk(mesh_conn, 32'h0);
    chk(yd_term, 32'h1);
    wait_yd(1'b0);
    freq_set <= 16'h1770;
    tick(4);
    freq_set <= 16'h176f;
    tick(30);
    chk(yd_term, 32'h0);
    wr(`DSSM_A_CTRL, 16'h8);
    $display("test winding done");
    wr(`DSSM_A_PRESET, 16'h5);
    power_w <= 16'h9c40;
    s0 = saves;
    term_run <= 1'b1;
    tick(4);
    // Stage table written while the motor runs
    wr(`DSSM_A_STAGE15, 16'h0fa0);
    tick(38);
    term_run <= 1'b0;
    tick(4);
    chk(saves - s0, 32'h1);
    rdc(ba(`DSSM_A_STAGE15), 32'hfa0);
    energy(tot);
    chk(tot % 40000, 32'h0);
    chk(tot > 32'hffff, 32'h1);
    tick(20);
    energy(tot2);
    chk(tot2, tot);
    term_run <= 1'b1;
    tick(30);
    power_down <= 1'b1;
    tick(3);
    chk(running, 32'h0);
    term_run <= 1'b0;
    power_down <= 1'b0;
    wr(`DSSM_A_PRESET, 16'h4);
    energy(tot2);
    chk(tot2 > tot, 32'h1);
    chk(tot2 % 40000, 32'h0);
    wr(`DSSM_A_PRESET, 16'h5);
    energy(tot);
    chk(tot, 32'h0);
    rdc(ba(`DSSM_A_EKWH_LO), 32'h0);
    rdc(ba(`DSSM_A_EKWH_HI), 32'h0);
    $display("test energy done");
    wr(`DSSM_A_OT_MIN, 16'h0);
    wr(`DSSM_A_OT_DAY, 16'h0);
    term_run <= 1'b1;
    tick(400);
    term_run <= 1'b0;
    tick(3);
    rdc(ba(`DSSM_A_OT_MIN), 32'h0);
    term_run <= 1'b1;
    tick(560);
    term_run <= 1'b0;
    tick(3);
    rdc(ba(`DSSM_A_OT_MIN), 32'h1);
    wr(`DSSM_A_OT_MIN, 16'h7);
    rdc(ba(`DSSM_A_OT_MIN), 32'h1);
    wr(`DSSM_A_OT_MIN, 16'h0);
    rdc(ba(`DSSM_A_OT_MIN), 32'h0);
    rdc(ba(`DSSM_A_OT_DAY), 32'h0);
    // Both runs together pass one kilowatt-hour at 40 kW
    rdc(ba(`DSSM_A_EKWH_LO), 32'h1);
    $display("test optime done");
    conclude();
  end
endmodule : tb_drive_speed_select_and_metering
